// *** rtl/psdc_top.sv ***
// Divider, output gating and lock detect control of the serially configured PLL synthesizer.
//
// The APB register port and the register addresses were chosen for this implementation.
`default_nettype none
module psdc_top
  import psdc_pkg::*;
#(
  parameter int LOCK_CNT_W = 8,
  parameter int REF_TIMEOUT = REF_TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial configuration pins.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic serial_load_strobe,
  // Clock sources from the analog section.
  input wire logic ref_clk_in,
  input wire logic vco_clk_in,
  // Output control and status pins.
  input wire logic out_enable,
  output logic synth_out_p,
  output logic synth_out_n,
  output logic locked_n
);

  if (LOCK_CNT_W < LOCKCFG_W) $error("LOCK_CNT_W must cover the lock count register");
  if (REF_TIMEOUT < 2) $error("REF_TIMEOUT must be at least 2");

  localparam int TO_W = $clog2(REF_TIMEOUT + 1);

  // Two flip-flop synchronisers plus one stage for edge detection.
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] sync3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {out_enable, vco_clk_in, ref_clk_in, serial_load_strobe, sdata, sclk};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic sclk_rise;
  logic load_rise;
  logic ref_rise;
  logic vco_rise;
  logic sdata_s;
  logic oe_s;
  assign sclk_rise = sync2[0] & ~sync3[0];
  assign sdata_s = sync2[1];
  assign load_rise = sync2[2] & ~sync3[2];
  assign ref_rise = sync2[3] & ~sync3[3];
  assign vco_rise = sync2[4] & ~sync3[4];
  assign oe_s = sync2[5];

  // Serial shift register; frame bits enter most significant first.
  logic [FRAME_W-1:0] shift;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift <= '0;
    end else if (sclk_rise) begin
      shift <= {shift[FRAME_W-2:0], sdata_s};
    end
  end

  // Active settings change only on the load strobe.
  psdc_div_type active;
  psdc_div_type next_active;
  logic custom;
  logic [IDX_W-1:0] preset_idx;
  always_comb begin
    if (shift[FR_CUSTOM_BIT]) begin
      next_active.p = shift[FR_P_LSB +: P_W];
      next_active.m = shift[FR_M_LSB +: M_W];
      next_active.n = shift[FR_N_LSB +: N_W];
    end else begin
      next_active = psdc_preset(shift[FR_IDX_LSB +: IDX_W]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= '{p: PRESET_P, m: PRESET_M_BASE, n: PRESET_N};
      custom <= 1'b0;
      preset_idx <= '0;
    end else if (load_rise) begin
      active <= next_active;
      custom <= shift[FR_CUSTOM_BIT];
      preset_idx <= shift[FR_IDX_LSB +: IDX_W];
    end
  end

  // Post divider: toggle the output every 2**code rising oscillator edges, with codes above 4 taken as 4.
  logic [N_W-1:0] n_code;
  logic [4:0] half_len;
  logic [4:0] post_cnt;
  logic div_clk;
  logic next_div_clk;
  logic post_wrap;
  assign n_code = (active.n > N_CODE_MAX) ? N_CODE_MAX : active.n;
  assign half_len = 5'(5'h01 << n_code);
  assign post_wrap = vco_rise && (post_cnt >= half_len - 5'h01);
  assign next_div_clk = post_wrap ? ~div_clk : div_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt <= '0;
      div_clk <= 1'b0;
    end else begin
      if (vco_rise) begin
        post_cnt <= post_wrap ? 5'h00 : post_cnt + 5'h01;
      end
      div_clk <= next_div_clk;
    end
  end

  // The gate may only change where the divided clock stays low, so a pulse is never cut.
  logic gate;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= 1'b0;
    end else if (!next_div_clk && !div_clk) begin
      gate <= oe_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_out_p <= 1'b0;
      synth_out_n <= 1'b1;
    end else begin
      synth_out_p <= div_clk & gate;
      synth_out_n <= ~(div_clk & gate);
    end
  end

  // Prescaler and feedback dividers feed the phase comparison.
  logic [P_W-1:0] pre_cnt;
  logic [M_W-1:0] fb_cnt;
  logic ref_tick;
  logic fb_tick;
  assign ref_tick = ref_rise && (pre_cnt + 5'h01 >= active.p);
  assign fb_tick = vco_rise && (fb_cnt + 10'h001 >= active.m);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
      fb_cnt <= '0;
    end else if (load_rise) begin
      pre_cnt <= '0;
      fb_cnt <= '0;
    end else begin
      if (ref_rise) begin
        pre_cnt <= ref_tick ? 5'h00 : pre_cnt + 5'h01;
      end
      if (vco_rise) begin
        fb_cnt <= fb_tick ? 10'h000 : fb_cnt + 10'h001;
      end
    end
  end

  // Lock detect: one feedback tick per reference period; a coincident tick opens the next period, as when aligned.
  logic [1:0] fb_seen;
  logic [LOCK_CNT_W-1:0] good;
  logic [TO_W-1:0] ref_idle;
  logic ref_lost;
  logic locked;
  logic [LOCKCFG_W-1:0] lockcfg;
  assign ref_lost = (ref_idle >= TO_W'(REF_TIMEOUT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_idle <= '0;
    end else if (ref_rise) begin
      ref_idle <= '0;
    end else if (!ref_lost) begin
      ref_idle <= ref_idle + TO_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_seen <= '0;
      good <= '0;
    end else if (load_rise || ref_lost) begin
      fb_seen <= '0;
      good <= '0;
    end else if (ref_tick) begin
      fb_seen <= {1'b0, fb_tick};
      if (fb_seen == 2'h1) begin
        if (good != '1) begin
          good <= good + LOCK_CNT_W'(1);
        end
      end else begin
        good <= '0;
      end
    end else if (fb_tick && fb_seen != 2'h3) begin
      fb_seen <= fb_seen + 2'h1;
    end
  end

  assign locked = (good >= LOCK_CNT_W'(lockcfg)) && (lockcfg != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_n <= 1'b1;
    end else begin
      locked_n <= ~locked;
    end
  end

  // APB slave: one access cycle, answered with pready registered from the setup cycle.
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_ACTIVE) ||
                   (paddr == ADDR_LOCKCFG) || (paddr == ADDR_SHIFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lockcfg <= LOCKCFG_RESET;
    end else if (apb_write && paddr == ADDR_LOCKCFG) begin
      lockcfg <= pwdata[LOCKCFG_W-1:0];
    end
  end

  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = '0;
    case (paddr)
      ADDR_STATUS: begin
        next_prdata[ST_LOCKED] = ~locked_n;
        next_prdata[ST_CUSTOM] = custom;
        next_prdata[ST_ENABLED] = gate;
        next_prdata[ST_IDX_LSB +: IDX_W] = preset_idx;
      end
      ADDR_ACTIVE: begin
        next_prdata[ACT_N_LSB +: N_W] = active.n;
        next_prdata[ACT_M_LSB +: M_W] = active.m;
        next_prdata[ACT_P_LSB +: P_W] = active.p;
      end
      ADDR_LOCKCFG: begin
        next_prdata[LOCKCFG_W-1:0] = lockcfg;
      end
      ADDR_SHIFT: begin
        next_prdata[FRAME_W-1:0] = shift;
      end
      default: begin
        next_prdata = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      prdata <= (apb_setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Checks kept next to the logic.
  AST_GATE_LOW_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(gate) |-> !div_clk && !$past(div_clk))
    else $error("Output gate changed while the divided clock was high");

  AST_DISABLED_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
    !gate |=> !synth_out_p && synth_out_n)
    else $error("Disabled output not held true low and complement high");

  AST_ENABLED_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    gate |=> synth_out_p == $past(div_clk) && synth_out_n == !$past(div_clk))
    else $error("Enabled output does not follow the divided clock");

  AST_LOCK_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 locked_n == !$past(locked))
    else $error("Lock indicator does not reflect lock state");

  AST_REF_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
    ref_lost |-> ##2 locked_n)
    else $error("Lock indicator not high after reference loss");

  AST_LOAD_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    !load_rise |=> $stable(active))
    else $error("Active dividers changed without a load strobe");

  AST_LOAD_CUSTOM: assert property (@(posedge pclk) disable iff (!presetn)
    load_rise && shift[FR_CUSTOM_BIT] |=> active.m == $past(shift[FR_M_LSB +: M_W]) &&
      active.p == $past(shift[FR_P_LSB +: P_W]))
    else $error("Custom frame not loaded into the dividers");

  AST_POST_DIV: assert property (@(posedge pclk) disable iff (!presetn)
    vco_rise |=> post_cnt < $past(half_len))
    else $error("Post divider count passed its half period");

  AST_SHIFT_IN: assert property (@(posedge pclk) disable iff (!presetn)
    sclk_rise |=> shift[0] == $past(sdata_s))
    else $error("Serial bit not shifted in on clock edge");

  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("APB access phase not answered in one cycle");

endmodule
`default_nettype wire

// *** rtl/psdc_pkg.sv ***
// Constants shared by the PLL synthesizer divider control block.
`default_nettype none
package psdc_pkg;
  // Divider field widths.
  localparam int P_W = 5;
  localparam int M_W = 10;
  localparam int N_W = 3;
  localparam int IDX_W = 4;
  localparam int PRESET_COUNT = 16;
  // Serial frame layout, shifted in most significant bit first.
  localparam int FRAME_W = 1 + IDX_W + P_W + M_W + N_W;
  localparam int FR_N_LSB = 0;
  localparam int FR_M_LSB = FR_N_LSB + N_W;
  localparam int FR_P_LSB = FR_M_LSB + M_W;
  localparam int FR_IDX_LSB = FR_P_LSB + P_W;
  localparam int FR_CUSTOM_BIT = FR_IDX_LSB + IDX_W;
  // Post divider codes 0 to 4 divide by 2, 4, 8, 16, 32.
  localparam logic [N_W-1:0] N_CODE_MAX = 3'h4;
  // APB register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ACTIVE = 8'h04;
  localparam logic [7:0] ADDR_LOCKCFG = 8'h08;
  localparam logic [7:0] ADDR_SHIFT = 8'h0C;
  // Register field positions.
  localparam int ST_LOCKED = 0;
  localparam int ST_CUSTOM = 1;
  localparam int ST_ENABLED = 2;
  localparam int ST_IDX_LSB = 4;
  localparam int ACT_N_LSB = 0;
  localparam int ACT_M_LSB = 8;
  localparam int ACT_P_LSB = 20;
  localparam int LOCKCFG_W = 8;
  localparam logic [LOCKCFG_W-1:0] LOCKCFG_RESET = 8'h04;
  // Reference loss timeout.
  localparam int CLK_MHZ = 50;
  localparam int REF_TIMEOUT_NS = 20000;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  // Preset table defaults.
  localparam logic [P_W-1:0] PRESET_P = 5'h01;
  localparam logic [M_W-1:0] PRESET_M_BASE = 10'h010;
  localparam logic [N_W-1:0] PRESET_N = 3'h1;

  typedef struct packed {
    logic [P_W-1:0] p;
    logic [M_W-1:0] m;
    logic [N_W-1:0] n;
  } psdc_div_type;

  function automatic psdc_div_type psdc_preset(input logic [IDX_W-1:0] idx);
    psdc_div_type d;
    d.p = PRESET_P;
    d.m = PRESET_M_BASE + M_W'(idx);
    d.n = PRESET_N;
    return d;
  endfunction
endpackage
`default_nettype wire

// *** verification/psdc_host_model.sv ***
// Host model that shifts divider frames into the serial configuration pins.
`default_nettype none
module psdc_host_model
  import psdc_pkg::*;
(
  // Clock and serial pins.
  input wire logic pclk,
  output logic sclk,
  output logic sdata,
  output logic serial_load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdata = 1'b1;
    serial_load_strobe = 1'b0;
  end
  // Whole frame, first bit on top; each level holds h edges for the synchroniser.
  task automatic shift(input logic [FRAME_W-1:0] f, input int h);
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      sdata <= f[i];
      repeat (h) @(posedge pclk);
      sclk <= 1'b1;
      repeat (h) @(posedge pclk);
      sclk <= 1'b0;
    end
    // The line is driven to the inverse of the last bit, so it stops showing the last bit.
    sdata <= ~f[0];
    repeat (h) @(posedge pclk);
  endtask
  // Strobe only after the frame is complete.
  task automatic load(input int h);
    serial_load_strobe <= 1'b1;
    repeat (h) @(posedge pclk);
    serial_load_strobe <= 1'b0;
    repeat (h) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** verification/pll_synth_divider_control_tb_top.sv ***
// Self-checking bench for the PLL synthesizer divider control block.
`default_nettype none
module pll_synth_divider_control_tb_top;
  import psdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, sclk, sdata, serial_load_strobe;
  logic ref_clk = 1'b0;
  logic vco = 1'b0;
  logic out_en = 1'b0;
  logic synth_out_p, synth_out_n, locked_n;
  int mismatches = 0, total_checks = 0, cyc = 0, run = 0, half = 0;
  int vdiv = 0, rcnt = 0, rhalf = 8, rstop = 0;
  initial forever #10 pclk = ~pclk;
  psdc_top #(.REF_TIMEOUT(300)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .sdata(sdata), .serial_load_strobe(serial_load_strobe), .ref_clk_in(ref_clk),
    .vco_clk_in(vco), .out_enable(out_en), .synth_out_p(synth_out_p), .synth_out_n(synth_out_n),
    .locked_n(locked_n));
  psdc_host_model host (.pclk(pclk), .sclk(sclk), .sdata(sdata), .serial_load_strobe(serial_load_strobe));
  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Oscillator as a slow level; a reference edge every M/2 oscillator rises keeps P=1 in lock.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    vdiv <= (vdiv + 1) % 4;
    if (vdiv == 3) vco <= ~vco;
    if (vdiv == 3 && !vco && rstop == 0) begin
      rcnt <= (rcnt == rhalf - 1) ? 0 : rcnt + 1;
      if (rcnt == rhalf - 1) ref_clk <= ~ref_clk;
    end
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end
  // A runt or stretched high phase shows as a wrong run length.
  always @(posedge pclk) begin
    if (synth_out_p === 1'b1) run <= run + 1;
    else begin
      if (run != 0 && half != 0) chk("high_time", half, run);
      run <= 0;
    end
    if (presetn) chk("out_n", {31'h0, ~synth_out_p}, 32'(synth_out_n));
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
    chk("pslverr", 0, e);
  endtask
  task automatic wlock(input logic lvl, input int lim);
    int n;
    n = 0;
    while (locked_n !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("locked_n", 32'(lvl), 32'(locked_n));
  endtask
  task automatic load(input logic [FRAME_W-1:0] f, input int h);
    half = 0;
    host.shift(f, h);
    host.load(h);
    repeat (600) @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    chk("out_p_rst", 0, 32'(synth_out_p));
    chk("locked_rst", 1, 32'(locked_n));
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_STATUS, 32'h0, "status");
    rd(ADDR_ACTIVE, 32'h0010_1001, "active_rst");
    rd(ADDR_LOCKCFG, 32'h4, "lockcfg");
    apb(1'b1, ADDR_LOCKCFG, 32'h0000_0006);
    rd(ADDR_LOCKCFG, 32'h6, "lockcfg_wr");
    apb(1'b1, ADDR_ACTIVE, 32'hFFFF_FFFF);
    rd(ADDR_ACTIVE, 32'h0010_1001, "active_ro");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 1, 32'(e));
    wlock(1'b0, 3000);
    rd(ADDR_STATUS, 32'h1, "status_lock");
    half = 16;
    for (int i = 0; i < 8; i++) begin
      out_en <= ~out_en;
      repeat (37 + 11 * i) @(posedge pclk);
    end
    repeat (40) @(posedge pclk);
    chk("out_p_off", 0, 32'(synth_out_p));
    chk("out_n_off", 1, 32'(synth_out_n));
    out_en <= 1'b1;
    host.shift({1'b1, 4'h0, 5'h01, 10'h014, 3'h0}, 3);
    rd(ADDR_ACTIVE, 32'h0010_1001, "active_hold");
    rhalf <= 10;
    // The last pass uses an out-of-range code, which must behave as divide by 32.
    for (int k = 0; k <= 5; k++) begin
      load({1'b1, 4'h0, 5'h01, 10'h014, (k == 5) ? 3'h7 : 3'(k)}, 3 + k % 2);
      rd(ADDR_ACTIVE, 32'h0010_1400 | ((k == 5) ? 7 : k), "active_cust");
      half = 8 << ((k == 5) ? 4 : k);
      repeat (600) @(posedge pclk);
    end
    wlock(1'b0, 3000);
    rd(ADDR_STATUS, 32'h7, "status_cust");
    rstop <= 1;
    wlock(1'b1, 400);
    rstop <= 0;
    load({1'b0, 4'h5, 18'h0}, 3);
    rd(ADDR_STATUS, 32'h54, "status_pre");
    rd(ADDR_ACTIVE, 32'h0010_1501, "active_pre");
    half = 16;
    repeat (200) @(posedge pclk);
    conclude();
  end
endmodule
`default_nettype wire
